// *** rtl/udc_pkg.sv ***
package udc_pkg;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [4:0] OFS_CTRL     = 5'h00;
   localparam logic [4:0] OFS_PRESET   = 5'h04;
   localparam logic [4:0] OFS_SETPOINT = 5'h08;
   localparam logic [4:0] OFS_COUNT    = 5'h0c;
   localparam logic [4:0] OFS_CAPTURE  = 5'h10;
   localparam logic [4:0] OFS_STATUS   = 5'h14;
   localparam logic [4:0] OFS_CMD      = 5'h18;

   // Control register field positions.
   localparam int CTRL_CMODE_LSB  = 0;
   localparam int CTRL_X4         = 2;
   localparam int CTRL_SW_DOWN    = 3;
   localparam int CTRL_SW_EN      = 4;
   localparam int CTRL_PMODE_LSB  = 5;
   localparam int CTRL_PEDGE_RISE = 8;
   localparam int CTRL_PCONFIRM   = 9;
   localparam int CTRL_MANUAL     = 10;
   localparam int CTRL_OUT_EN_LSB = 11;
   localparam int CTRL_MAN_LSB    = 13;
   localparam int CTRL_W          = 15;

   // Status register field positions.
   localparam int STAT_CNT_OUT_LSB = 0;
   localparam int STAT_DOWN        = 2;
   localparam int STAT_ENABLED     = 3;
   localparam int STAT_PRESET_LVL  = 4;
   localparam int STAT_LCAM_ARMED  = 5;

   // Command register field positions.
   localparam int CMD_SW_PRESET = 0;

   // Values after reset.
   localparam logic [CTRL_W-1:0] CTRL_RST  = 15'h0000;
   localparam logic [31:0]       VALUE_RST = 32'h0000_0000;

   // Direction input must be steady longer than this before a pulse counts.
   localparam int CLK_PERIOD_NS   = 100;
   localparam int DIR_SETTLE_NS   = 3000;
   localparam int DIR_SETTLE_CYC  =
      (DIR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W        = 6;

   typedef enum logic [1:0] {
      CM_SEPARATE,
      CM_PULSE_DIR,
      CM_SW_DIR,
      CM_QUAD
   } udc_cmode_t;

   typedef enum logic [2:0] {
      PM_NONE,
      PM_EDGE,
      PM_DIR_MATCH,
      PM_DIR_OPPOSED,
      PM_LEVEL,
      PM_SHORT_CAM,
      PM_LONG_CAM
   } udc_pmode_t;

   typedef struct packed {
      logic capture_in;
      logic count_enable_in;
      logic preset_in;
      logic index_mark_in;
      logic aux_count_in;
      logic count_pulse_in;
   } udc_pins_t;

   localparam int PINS_W = 6;

endpackage

// *** rtl/udc_channel.sv ***
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Operation
// (RL1) Separate mode: count pulse input counts up, auxiliary input counts down.
// (RL2) Separate mode: coincident pulses on both inputs are each counted.
// (RL3) Pulse-direction mode: auxiliary 0 counts up, auxiliary 1 counts down.
// (RL4) Pulse-direction up: pulse counts only after direction input steady over 3 us.
// (RL5) Pulse-direction down: pulse ignored unless direction input steady over 3 us.
// (RL6) Software-direction mode: pulses on count input, direction from software bit.
// (RL7) Quadrature: A on count input, B on auxiliary input give direction.
// (RL8) Quadrature x1: count changes only on rising edges of B.
// (RL9) Quadrature x4: count changes on every edge of A and B.
// (RL10) Edge preset: configured preset input edge loads preset, when confirmed.
// (RL11) Direction-matched preset: rise when up, fall when down, when confirmed.
// (RL12) Direction-opposed preset: rise when down, fall when up, when confirmed.
// (RL13) Level preset: count held at preset while preset input is 1.
// (RL14) Short cam up: preset input 1 and index rise loads preset.
// (RL15) Short cam down: preset input 1 and index fall loads preset.
// (RL16) Short cam: every active index edge in the cam presets again.
// (RL17) Long cam: first index rise after preset input returns to 0 presets.
// (RL18) Automatic: enabled reflex output follows its counter output.
// (RL19) Automatic: disabled reflex output is driven 0.
// (RL20) Manual: reflex outputs follow software-written states.
// (RL21) Counting enabled by enable input at 1 or software enable.
// (RL22) Up counting sets output 0 past setpoint, cleared on reload; the code sets it when the count reaches the setpoint.
// (RL23) Down counting sets output 1 at zero, cleared on reload.
// (RL24) All pin inputs synchronised to core clock, edges detected there.
// (RL25) Capture input edge copies count into readable capture register.
module udc_channel #(
   parameter int CNT_W = 32
) (
   // Clock and reset.
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   // Avalon-MM slave.
   input  wire logic [4:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   output logic      [31:0]       avs_readdata_o,
   output logic                   avs_waitrequest_o,
   // Sensor and encoder pins.
   input  wire udc_pkg::udc_pins_t pins_i,
   // Reflex outputs.
   output logic                   reflex_out_0_o,
   output logic                   reflex_out_1_o
);

   localparam int PW = udc_pkg::PINS_W;
   localparam int SW = udc_pkg::SETTLE_W;
   localparam logic [SW-1:0] SETTLE_LIM = SW'(udc_pkg::DIR_SETTLE_CYC);

   logic [PW-1:0]             s1_r;
   logic [PW-1:0]             s2_r;
   logic [PW-1:0]             s3_r;
   logic [PW-1:0]             lvl_r;
   logic [PW-1:0]             prev_r;
   udc_pkg::udc_pins_t        lvl;
   udc_pkg::udc_pins_t        rise;
   udc_pkg::udc_pins_t        fall;
   logic [udc_pkg::CTRL_W-1:0] ctrl_r;
   logic [CNT_W-1:0]          preset_r;
   logic [CNT_W-1:0]          setpoint_r;
   logic [CNT_W-1:0]          count_r;
   logic [CNT_W-1:0]          capture_r;
   logic [1:0]                cnt_out_r;
   logic                      down_r;
   logic                      lcam_armed_r;
   logic [SW-1:0]             settle_r;
   logic                      ack_r;
   logic [31:0]               rdata_r;
   logic                      wr_acc;
   logic                      sw_preset;
   udc_pkg::udc_cmode_t       cmode;
   udc_pkg::udc_pmode_t       pmode;
   logic                      enabled;
   logic                      step_up;
   logic                      step_dn;
   logic                      dir_down;
   logic                      load_evt;
   logic                      hold_lvl;
   logic                      confirm;

   function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
      widen = 32'(v);
   endfunction

   // Three-stage synchroniser; a level moves only when stages two and three
   // agree, so a single-cycle glitch at the pin never reaches the counter.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         lvl_r  <= '0;
         prev_r <= '0;
      end else begin
         s1_r   <= pins_i; // RL24
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         lvl_r  <= (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r)); // RL24
         prev_r <= lvl_r;
      end
   end

   assign lvl  = lvl_r;
   assign rise = lvl_r & ~prev_r; // RL24
   assign fall = ~lvl_r & prev_r; // RL24

   assign cmode   = udc_pkg::udc_cmode_t'(ctrl_r[udc_pkg::CTRL_CMODE_LSB +: 2]);
   assign pmode   = udc_pkg::udc_pmode_t'(ctrl_r[udc_pkg::CTRL_PMODE_LSB +: 3]);
   assign confirm = ctrl_r[udc_pkg::CTRL_PCONFIRM];
   assign enabled = lvl.count_enable_in | ctrl_r[udc_pkg::CTRL_SW_EN]; // RL21

   // Cycles the direction input has been steady, saturating.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         settle_r <= '0;
      end else if (rise.aux_count_in || fall.aux_count_in) begin
         settle_r <= '0;
      end else if (settle_r != '1) begin
         settle_r <= settle_r + SW'(1);
      end
   end

   // Count steps from the selected input mode.
   always_comb begin
      step_up = 1'b0;
      step_dn = 1'b0;
      unique case (cmode)
         udc_pkg::CM_SEPARATE: begin
            step_up = rise.count_pulse_in; // RL1
            step_dn = rise.aux_count_in;   // RL1
         end
         udc_pkg::CM_PULSE_DIR: begin
            if (rise.count_pulse_in && settle_r > SETTLE_LIM) begin // RL4 RL5
               step_up = ~lvl.aux_count_in; // RL3
               step_dn = lvl.aux_count_in;  // RL3
            end
         end
         udc_pkg::CM_SW_DIR: begin
            step_up = rise.count_pulse_in & ~ctrl_r[udc_pkg::CTRL_SW_DOWN]; // RL6
            step_dn = rise.count_pulse_in & ctrl_r[udc_pkg::CTRL_SW_DOWN];  // RL6
         end
         udc_pkg::CM_QUAD: begin
            if (!ctrl_r[udc_pkg::CTRL_X4]) begin
               // A leads B when A is high at the rising edge of B.
               step_up = rise.aux_count_in & lvl.count_pulse_in;  // RL8 RL7
               step_dn = rise.aux_count_in & ~lvl.count_pulse_in; // RL8 RL7
            end else if ((lvl_r[0] ^ prev_r[0]) != (lvl_r[1] ^ prev_r[1])) begin
               // Exactly one input moved; both at once is a lost step.
               step_up = lvl.count_pulse_in ^ prev_r[1];  // RL9 RL7
               step_dn = ~(lvl.count_pulse_in ^ prev_r[1]); // RL9 RL7
            end
         end
      endcase
   end

   // Direction used by the preset modes: software bit, direction input level or last step taken.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         down_r <= 1'b0;
      end else if (cmode == udc_pkg::CM_SW_DIR) begin
         down_r <= ctrl_r[udc_pkg::CTRL_SW_DOWN];
      end else if (cmode == udc_pkg::CM_PULSE_DIR) begin
         down_r <= lvl.aux_count_in;
      end else if (step_up != step_dn) begin
         down_r <= step_dn;
      end
   end
   assign dir_down = down_r;

   // Long cam arms on the preset input falling and fires on the next index rise.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lcam_armed_r <= 1'b0;
      end else if (pmode != udc_pkg::PM_LONG_CAM || lvl.preset_in) begin
         lcam_armed_r <= 1'b0;
      end else if (fall.preset_in) begin
         lcam_armed_r <= 1'b1; // RL17
      end else if (rise.index_mark_in) begin
         lcam_armed_r <= 1'b0; // RL17
      end
   end

   // Preset events; the confirm bit gates every hardware preset mode.
   always_comb begin
      load_evt = 1'b0;
      hold_lvl = 1'b0;
      unique case (pmode)
         udc_pkg::PM_NONE: begin
            load_evt = 1'b0;
         end
         udc_pkg::PM_EDGE: begin
            load_evt = ctrl_r[udc_pkg::CTRL_PEDGE_RISE] ? rise.preset_in
                                                        : fall.preset_in; // RL10
         end
         udc_pkg::PM_DIR_MATCH: begin
            load_evt = dir_down ? fall.preset_in : rise.preset_in; // RL11
         end
         udc_pkg::PM_DIR_OPPOSED: begin
            load_evt = dir_down ? rise.preset_in : fall.preset_in; // RL12
         end
         udc_pkg::PM_LEVEL: begin
            hold_lvl = lvl.preset_in; // RL13
         end
         udc_pkg::PM_SHORT_CAM: begin
            // Each active index edge inside the cam reloads again.
            load_evt = lvl.preset_in & (dir_down ? fall.index_mark_in
                                                 : rise.index_mark_in); // RL14 RL15 RL16
         end
         udc_pkg::PM_LONG_CAM: begin
            load_evt = lcam_armed_r & rise.index_mark_in; // RL17
         end
         default: begin
            load_evt = 1'b0;
         end
      endcase
      load_evt = (load_evt & confirm) | sw_preset;
      hold_lvl = hold_lvl & confirm;
   end

   // Current count; a preset wins over a count step in the same cycle.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_r <= CNT_W'(udc_pkg::VALUE_RST);
      end else if (load_evt || hold_lvl) begin
         count_r <= preset_r; // RL13
      end else if (enabled && step_up && !step_dn) begin
         count_r <= count_r + CNT_W'(1);
      end else if (enabled && step_dn && !step_up) begin
         count_r <= count_r - CNT_W'(1);
      end
   end
   // Coincident up and down pulses both count and cancel each other. RL2

   // Counter outputs; a reload clears both.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_out_r <= 2'h0;
      end else if (load_evt || hold_lvl) begin
         cnt_out_r <= 2'h0; // RL22 RL23
      end else if (enabled && step_up != step_dn) begin
         if (step_up && count_r + CNT_W'(1) == setpoint_r) begin
            cnt_out_r[0] <= 1'b1; // RL22
         end
         if (step_dn && count_r == CNT_W'(1)) begin
            cnt_out_r[1] <= 1'b1; // RL23
         end
      end
   end

   // Capture on a rising edge of the capture input.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         capture_r <= CNT_W'(udc_pkg::VALUE_RST);
      end else if (rise.capture_in) begin
         capture_r <= count_r; // RL25
      end
   end

   // Reflex outputs.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reflex_out_0_o <= 1'b0;
         reflex_out_1_o <= 1'b0;
      end else if (ctrl_r[udc_pkg::CTRL_MANUAL]) begin
         reflex_out_0_o <= ctrl_r[udc_pkg::CTRL_MAN_LSB];     // RL20
         reflex_out_1_o <= ctrl_r[udc_pkg::CTRL_MAN_LSB + 1]; // RL20
      end else begin
         reflex_out_0_o <= ctrl_r[udc_pkg::CTRL_OUT_EN_LSB] & cnt_out_r[0];     // RL18 RL19
         reflex_out_1_o <= ctrl_r[udc_pkg::CTRL_OUT_EN_LSB + 1] & cnt_out_r[1]; // RL18 RL19
      end
   end

   // Avalon-MM slave: every access waits exactly one cycle, which gives the
   // registered read data time to settle without a combinational path.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
      end
   end
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
   assign wr_acc    = avs_write_i & ack_r;
   assign sw_preset = wr_acc && avs_address_i == udc_pkg::OFS_CMD
                      && avs_writedata_i[udc_pkg::CMD_SW_PRESET];

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_r     <= udc_pkg::CTRL_RST;
         preset_r   <= CNT_W'(udc_pkg::VALUE_RST);
         setpoint_r <= CNT_W'(udc_pkg::VALUE_RST);
      end else if (wr_acc) begin
         case (avs_address_i)
            udc_pkg::OFS_CTRL:     ctrl_r     <= avs_writedata_i[udc_pkg::CTRL_W-1:0];
            udc_pkg::OFS_PRESET:   preset_r   <= avs_writedata_i[CNT_W-1:0];
            udc_pkg::OFS_SETPOINT: setpoint_r <= avs_writedata_i[CNT_W-1:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read_i && !ack_r) begin
         case (avs_address_i)
            udc_pkg::OFS_CTRL:     rdata_r <= 32'(ctrl_r);
            udc_pkg::OFS_PRESET:   rdata_r <= widen(preset_r);
            udc_pkg::OFS_SETPOINT: rdata_r <= widen(setpoint_r);
            udc_pkg::OFS_COUNT:    rdata_r <= widen(count_r);
            udc_pkg::OFS_CAPTURE:  rdata_r <= widen(capture_r);
            udc_pkg::OFS_STATUS:   rdata_r <= {26'h0, lcam_armed_r,
                                               lvl.preset_in, enabled,
                                               down_r, cnt_out_r};
            default:               rdata_r <= 32'h0000_0000;
         endcase
      end
   end
   assign avs_readdata_o = rdata_r;

endmodule

`default_nettype wire

// *** test/udc_channel_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module udc_channel_monitor (
   // Clock and reset.
   input wire logic               clk_i,
   input wire logic               arst_n_i,
   // Register bus.
   input wire logic [4:0]         avs_address_i,
   input wire logic               avs_read_i,
   input wire logic               avs_write_i,
   input wire logic [31:0]        avs_writedata_i,
   input wire logic [31:0]        avs_readdata_o,
   input wire logic               avs_waitrequest_o,
   // Pins and reflex outputs.
   input wire udc_pkg::udc_pins_t pins_i,
   input wire logic               reflex_out_0_o,
   input wire logic               reflex_out_1_o
);
   // Shadow of the control register, rebuilt from completed writes.
   logic [14:0] ctrl_r;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_r <= 15'h0000;
      end else if (avs_write_i && !avs_waitrequest_o &&
                   avs_address_i == udc_pkg::OFS_CTRL) begin
         ctrl_r <= avs_writedata_i[14:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_req_wait;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_rd_done;
      avs_read_i && !avs_waitrequest_o;
   endsequence
   a_bus_one_wait: assert property (s_req_wait |=> !avs_waitrequest_o)
      else $error("waitrequest held longer than one cycle");
   a_bus_idle_free: assert property
      (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("waitrequest high without a request");
   a_bus_first_wait: assert property
      ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
      else $error("request answered in its first cycle");
   a_rdata_hold: assert property
      (!$past(avs_read_i) |-> $stable(avs_readdata_o))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property
      (s_rd_done ##0 avs_address_i > 5'h18 |-> avs_readdata_o == 32'h0)
      else $error("unmapped read returned nonzero");
   a_ctrl_readback: assert property (s_rd_done ##0
      avs_address_i == udc_pkg::OFS_CTRL |-> avs_readdata_o == 32'(ctrl_r))
      else $error("control readback differs from written value");
   a_manual_out0: assert property ($stable(ctrl_r) && ctrl_r[10] |->
      reflex_out_0_o == ctrl_r[13])
      else $error("manual reflex 0 differs from software state");
   a_manual_out1: assert property ($stable(ctrl_r) && ctrl_r[10] |->
      reflex_out_1_o == ctrl_r[14])
      else $error("manual reflex 1 differs from software state");
   a_auto_off0: assert property ($stable(ctrl_r) && !ctrl_r[10] &&
      !ctrl_r[11] |-> !reflex_out_0_o)
      else $error("disabled reflex 0 is driven high");
   a_auto_off1: assert property ($stable(ctrl_r) && !ctrl_r[10] &&
      !ctrl_r[12] |-> !reflex_out_1_o)
      else $error("disabled reflex 1 is driven high");
endmodule
bind udc_channel udc_channel_monitor u_mon (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .pins_i(pins_i),
   .reflex_out_0_o(reflex_out_0_o), .reflex_out_1_o(reflex_out_1_o));
`default_nettype wire

// *** test/udc_sensor_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Sensors and encoder; every level is held for the cycles the caller gives,
// at least two in this testbench, so the channel's input filter can see it.
module udc_sensor_model (
   // Clock.
   input  wire logic              clk_i,
   // Pins towards the channel.
   output var udc_pkg::udc_pins_t pins_o
);
   logic [1:0] ph;
   initial begin
      pins_o = '0;
      ph = 2'h0;
   end
   task automatic lvl(input logic [5:0] m, input logic v, input int n);
      pins_o <= v ? (pins_o | m) : (pins_o & ~m);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic pulse(input logic [5:0] m, input int n);
      lvl(m, 1'b1, n);
      lvl(m, 1'b0, n);
   endtask
   // Gray phase keeps A and B a quarter period apart.
   task automatic quad(input logic up, input int k, input int n);
      repeat (k) begin
         ph = up ? ph + 2'h1 : ph - 2'h1;
         pins_o.count_pulse_in <= ph[1] ^ ph[0];
         pins_o.aux_count_in   <= ph[1];
         repeat (n) @(posedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

// *** test/udc_channel_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module udc_channel_tb;
   localparam int W = 16;
   localparam logic [5:0] PA = 6'h01, PB = 6'h02, PZ = 6'h04;
   localparam logic [5:0] PP = 6'h08, PE = 6'h10, PK = 6'h20;
   localparam logic [31:0] EN = 32'h10, DN = 32'h8, CF = 32'h200;
   localparam logic [31:0] RI = 32'h100, X4 = 32'h4, B = 32'h12;
   localparam logic [31:0] PT [7] = '{B | 32'h20 | RI | CF, B | 32'h20 | CF,
      B | 32'h20 | RI, B | 32'h40 | CF, B | 32'h40 | CF | DN,
      B | 32'h60 | CF, B | 32'h60 | CF | DN};
   localparam logic [6:0] LA = 7'b1001001, LB = 7'b1111011;
   logic               clk_i = 1'b0, arst_n_i = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [4:0]         adr = 5'h00;
   logic [31:0]        wd = 32'h0, rdat;
   logic               wreq, ro0, ro1;
   logic [W-1:0]       p;
   logic [31:0]        eq [$], mq [$];
   udc_pkg::udc_pins_t pins;
   int                 err_count = 0, num_checks = 0, seed = 32'h099dccd1;
   always #50 clk_i = ~clk_i;
   udc_channel #(.CNT_W(W)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .pins_i(pins), .reflex_out_0_o(ro0), .reflex_out_1_o(ro1));
   udc_sensor_model enc (.clk_i(clk_i), .pins_o(pins));
   task automatic cmp(input logic [31:0] a, input logic [31:0] e);
      num_checks++;
      if (a !== e) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, a, e);
      end
   endtask
   task automatic summarize;
      if (err_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Completed reads are compared against the oldest noted expectation.
   always @(posedge clk_i) begin
      if (rd && !wreq) cmp(rdat & mq.pop_front(), eq.pop_front());
   end
   task automatic ac(input logic w, input logic [4:0] a,
                     input logic [31:0] d, input logic [31:0] m = '1);
      if (!w) begin
         eq.push_back(d & m);
         mq.push_back(m);
      end
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= w ? d : 32'h0;
      @(posedge clk_i);
      // Nothing here times out; only the watchdog ends a wait that the slave never answers.
      while (wreq) begin
         @(posedge clk_i);
      end
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_i);
   endtask
   function automatic int h();
      return 3 + ($unsigned($random(seed)) % 4);
   endfunction
   // A pin change reaches the count five edges later.
   task automatic rdw(input logic [4:0] a, input logic [31:0] e,
                      input logic [31:0] m = '1);
      repeat (6) @(posedge clk_i);
      ac(1'b0, a, e, m);
   endtask
   task automatic cnt(input logic [W-1:0] e);
      rdw(udc_pkg::OFS_COUNT, 32'(e));
   endtask
   task automatic ld(input logic [W-1:0] v);
      ac(1'b1, udc_pkg::OFS_PRESET, 32'(v));
      ac(1'b1, udc_pkg::OFS_CMD, 32'h1);
   endtask
   task automatic prep(input logic [31:0] c);
      ld('0);
      p = W'($random(seed)) | 16'h1;
      ac(1'b1, udc_pkg::OFS_PRESET, 32'(p));
      ac(1'b1, udc_pkg::OFS_CTRL, c);
   endtask
   task automatic qc(input logic [1:0] e);
      repeat (2) @(posedge clk_i);
      cmp({30'h0, ro1, ro0}, {30'h0, e});
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      summarize;
   end
   initial begin
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      ac(1'b0, udc_pkg::OFS_CTRL, 32'h0);
      ac(1'b0, 5'h1c, 32'h0);
      ac(1'b1, udc_pkg::OFS_COUNT, 32'h5);
      cnt(0);
      enc.pulse(PA, h());
      cnt(0);
      enc.lvl(PE, 1'b1, h());
      enc.pulse(PA, h());
      enc.lvl(PE, 1'b0, h());
      cnt(1);
      ac(1'b1, udc_pkg::OFS_CTRL, EN);
      repeat (3) enc.pulse(PA, h());
      enc.pulse(PB, h());
      cnt(3);
      enc.pulse(PA | PB, h());
      enc.lvl(PA, 1'b1, h());
      repeat (2) enc.pulse(PB, h());
      enc.lvl(PA, 1'b0, h());
      cnt(2);
      repeat (3) enc.pulse(PB, h());
      cnt(16'hffff);
      ac(1'b1, udc_pkg::OFS_CTRL, EN | 32'h1);
      ld(100);
      enc.lvl(PB, 1'b1, 40);
      enc.pulse(PA, h());
      cnt(99);
      enc.lvl(PB, 1'b0, 2);
      enc.pulse(PA, 3);
      cnt(99);
      repeat (40) @(posedge clk_i);
      enc.pulse(PA, h());
      cnt(100);
      enc.lvl(PB, 1'b1, 2);
      enc.pulse(PA, 3);
      cnt(100);
      enc.lvl(PB, 1'b0, 40);
      ac(1'b1, udc_pkg::OFS_CTRL, B | DN);
      repeat (2) enc.pulse(PA, h());
      cnt(98);
      ac(1'b1, udc_pkg::OFS_CTRL, B);
      enc.pulse(PA, h());
      cnt(99);
      ac(1'b1, udc_pkg::OFS_CTRL, EN | 32'h3);
      enc.quad(1'b1, 4, h());
      cnt(100);
      enc.quad(1'b0, 4, h());
      cnt(99);
      ac(1'b1, udc_pkg::OFS_CTRL, EN | 32'h3 | X4);
      enc.quad(1'b1, 4, h());
      cnt(103);
      enc.quad(1'b0, 4, h());
      cnt(99);
      for (int i = 0; i < 7; i++) begin
         prep(PT[i]);
         enc.lvl(PP, 1'b1, h());
         cnt(LA[i] ? p : '0);
         enc.lvl(PP, 1'b0, h());
         cnt(LB[i] ? p : '0);
      end
      prep(B | 32'h80 | CF);
      enc.lvl(PP, 1'b1, h());
      enc.pulse(PA, h());
      cnt(p);
      enc.lvl(PP, 1'b0, h());
      enc.pulse(PA, h());
      cnt(p + 1'b1);
      prep(B | 32'ha0 | CF);
      enc.lvl(PP, 1'b1, h());
      enc.pulse(PZ, h());
      enc.pulse(PA, h());
      cnt(p + 1'b1);
      enc.pulse(PZ, h());
      cnt(p);
      enc.lvl(PP, 1'b0, h());
      enc.pulse(PA, h());
      enc.pulse(PZ, h());
      cnt(p + 1'b1);
      prep(B | 32'ha0 | CF | DN);
      enc.lvl(PP, 1'b1, h());
      enc.lvl(PZ, 1'b1, h());
      cnt(0);
      enc.lvl(PZ, 1'b0, h());
      cnt(p);
      prep(B | 32'hc0 | CF);
      enc.pulse(PZ, h());
      cnt(0);
      enc.lvl(PP, 1'b0, h());
      enc.pulse(PZ, h());
      enc.pulse(PA, h());
      enc.pulse(PZ, h());
      cnt(p + 1'b1);
      enc.pulse(PK, h());
      enc.pulse(PA, h());
      rdw(udc_pkg::OFS_CAPTURE, 32'(W'(p + 1'b1)));
      ac(1'b1, udc_pkg::OFS_CTRL, EN);
      ld(3);
      ac(1'b1, udc_pkg::OFS_SETPOINT, 32'h5);
      enc.pulse(PA, h());
      rdw(udc_pkg::OFS_STATUS, 32'h0, 32'h1);
      enc.pulse(PA, h());
      rdw(udc_pkg::OFS_STATUS, 32'h1, 32'h1);
      ac(1'b1, udc_pkg::OFS_CTRL, EN | 32'h800);
      qc(2'b01);
      ac(1'b1, udc_pkg::OFS_CTRL, EN);
      qc(2'b00);
      ac(1'b1, udc_pkg::OFS_CTRL, EN | 32'h2400);
      qc(2'b01);
      ac(1'b1, udc_pkg::OFS_CTRL, EN | 32'h4400);
      qc(2'b10);
      ld(2);
      rdw(udc_pkg::OFS_STATUS, 32'h0, 32'h3);
      ac(1'b1, udc_pkg::OFS_CTRL, B | DN | 32'h1000);
      repeat (2) enc.pulse(PA, h());
      rdw(udc_pkg::OFS_STATUS, 32'h2, 32'h3);
      qc(2'b10);
      summarize;
   end
endmodule
`default_nettype wire
